// ===== slm_top.sv
// Four-port SONET receive line status monitor with APB register access
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "slm_defs.svh"
module slm_top import slm_pkg::*; #(
  parameter int NP = `SLM_NUM_PORTS,
  parameter int ADDR_W = 8,
  parameter int LOF_SET_CYC = `SLM_LOF_SET_MS * `SLM_PCLK_MHZ * 1000,
  parameter int LOF_CLR_CYC = `SLM_LOF_CLR_MS * `SLM_PCLK_MHZ * 1000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line side, per port, asynchronous to pclk
  input wire logic [NP-1:0] line_clk,
  input wire logic [NP-1:0] los_in,
  input wire logic [NP-1:0] oof_in,
  input wire logic [NP-1:0] sig_detect,
  input wire logic [NP-1:0] mod_present,
  input wire logic [NP-1:0] laser_on,
  input wire logic [NP-1:0] b1_err_tgl,
  input wire logic [NP-1:0] b2_err_tgl,
  input wire logic [NP-1:0] b3_err_tgl,
  input wire logic [NP-1:0] ptr_lock_in,
  input wire logic [NP-1:0] rx_concat_in,
  input wire logic [NP-1:0][7:0] c2_in,
  input wire logic [NP-1:0][7:0] vc_in,
  // Per-port settings
  output logic [NP-1:0] cfg_oc12,
  output logic [NP-1:0] cfg_master,
  output logic [NP-1:0] concatenated_mapping,
  output logic [NP-1:0] cfg_pos,
  output logic [NP-1:0][1:0] cfg_crc,
  output logic [NP-1:0] cfg_pass_idle,
  output logic [NP-1:0] optics_pwr,
  output logic [NP-1:0][15:0] rec_len,
  output logic [NP-1:0] tx_clk_loop,
  // Per-port line status
  output logic [NP-1:0] los_out,
  output logic [NP-1:0] lof_out,
  output logic [NP-1:0] oof_out,
  output logic [NP-1:0][1:0] pointer_state
);
  // ==========================================================================
  // Sizes
  localparam int IW = $clog2(NP);
  localparam int CNT_MAX = (LOF_SET_CYC > LOF_CLR_CYC) ? LOF_SET_CYC : LOF_CLR_CYC;
  localparam int CW = $clog2(CNT_MAX + 2);
  localparam int QUIET_CYC = `SLM_CLKLOSS_NS / `SLM_PCLK_NS;
  localparam int SW = `SLM_IN_W;

  typedef struct packed {
    logic [NP-1:0][SW-1:0] prev;
    logic [NP-1:0][CW-1:0] lof_cnt;
    logic [NP-1:0] lof;
    logic [NP-1:0][7:0] quiet;
    logic [NP-1:0] los;
    logic [NP-1:0] oof;
    logic [NP-1:0][2:0] bip;
    logic [NP-1:0] c2chg;
    logic [NP-1:0] c2_seen;
    logic [NP-1:0][7:0] c2;
    logic [NP-1:0][1:0] ptr;
    logic [NP-1:0][7:0] vc;
    logic [NP-1:0] tx_loop;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } slm_top_st_t;

  slm_top_st_t r_reg;
  slm_top_st_t r_next;

  // ==========================================================================
  // Synchronisers
  logic [NP-1:0][SW-1:0] raw_in;
  logic [NP-1:0][SW-1:0] sync_q;

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      raw_in[p] = {vc_in[p], c2_in[p], rx_concat_in[p], ptr_lock_in[p], b3_err_tgl[p],
                   b2_err_tgl[p], b1_err_tgl[p], laser_on[p], mod_present[p],
                   sig_detect[p], oof_in[p], los_in[p], line_clk[p]};
    end
  end

  // The C2 label is only taken once it holds still across a line clock edge; the VC number is taken every cycle
  slm_sync #(.WIDTH(NP * SW)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(raw_in),
    .sync_out(sync_q)
  );

  // ==========================================================================
  // Address decode: {hit, is_status, index}
  function automatic logic [IW+1:0] dec(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rc;
    logic [ADDR_W-1:0] rs;
    logic [ADDR_W-1:0] span;
    rc = a - ADDR_W'(`SLM_CFG_BASE);
    rs = a - ADDR_W'(`SLM_STAT_BASE);
    span = ADDR_W'(4 * NP);
    if (a[1:0] != 2'b00) begin
      dec = '0;
    end else if (rc < span) begin
      dec = {1'b1, 1'b0, rc[IW+1:2]};
    end else if (rs < span) begin
      dec = {1'b1, 1'b1, rs[IW+1:2]};
    end else begin
      dec = '0;
    end
  endfunction : dec

  logic [IW+1:0] d;
  logic acc;
  logic done;
  logic cfg_we;
  logic [31:0] cfg_wdata;
  logic [31:0] cfg_rdata;
  logic [NP-1:0][31:0] cfg_words;
  logic [NP-1:0] rd_clr;

  assign d = dec(paddr);
  assign acc = psel & penable;
  assign done = acc & r_reg.pready;
  assign cfg_we = done & pwrite & d[IW+1] & ~d[IW];

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      cfg_wdata[8*b +: 8] = pstrb[b] ? pwdata[8*b +: 8] : cfg_words[d[IW-1:0]][8*b +: 8];
    end
  end

  // Reading a status word clears that port's latched error flags
  always_comb begin
    rd_clr = '0;
    if (done & ~pwrite & d[IW+1] & d[IW]) begin
      rd_clr[d[IW-1:0]] = 1'b1;
    end
  end

  slm_cfg_mem #(.NP(NP), .IW(IW)) u_cfg (
    .clk(pclk),
    .rst_n(presetn),
    .we(cfg_we),
    .waddr(d[IW-1:0]),
    .wdata(cfg_wdata),
    .raddr(d[IW-1:0]),
    .rdata(cfg_rdata),
    .words(cfg_words)
  );

  // ==========================================================================
  // Status word of one port
  function automatic logic [31:0] stat_word(input slm_top_st_t s, input int p);
    stat_word = 32'h0000_0000;
    stat_word[`SLM_ST_LOS] = s.los[p];
    stat_word[`SLM_ST_LOF] = s.lof[p];
    stat_word[`SLM_ST_OOF] = s.oof[p];
    stat_word[`SLM_ST_BIP_LO +: 3] = s.bip[p];
    stat_word[`SLM_ST_C2CHG] = s.c2chg[p];
    stat_word[`SLM_ST_PTR_LO +: 2] = s.ptr[p];
    stat_word[`SLM_ST_SIG] = s.prev[p][`SLM_IN_SIG];
    stat_word[`SLM_ST_MOD] = s.prev[p][`SLM_IN_MOD];
    stat_word[`SLM_ST_LASER] = s.prev[p][`SLM_IN_LASER];
    stat_word[`SLM_ST_C2_LO +: 8] = s.c2[p];
    stat_word[`SLM_ST_VC_LO +: 8] = s.vc[p];
  endfunction : stat_word

  // ==========================================================================
  // Line status and APB
  always_comb begin
    logic [SW-1:0] cur;
    logic concat_cfg;
    logic lclk_rise;
    logic [7:0] c2_now;
    r_next = r_reg;
    cur = '0;
    concat_cfg = 1'b0;
    lclk_rise = 1'b0;
    c2_now = 8'h00;
    for (int p = 0; p < NP; p++) begin
      cur = sync_q[p];
      concat_cfg = cfg_words[p][`SLM_CFG_CONCAT];
      lclk_rise = cur[`SLM_IN_LCLK] & ~r_reg.prev[p][`SLM_IN_LCLK];
      c2_now = cur[`SLM_IN_C2_LO +: 8];
      // A recovered clock that stops counts as no signal
      if (lclk_rise) begin
        r_next.quiet[p] = 8'h00;
      end else if (r_reg.quiet[p] != 8'(QUIET_CYC)) begin
        r_next.quiet[p] = r_reg.quiet[p] + 8'h01;
      end
      r_next.los[p] = cur[`SLM_IN_LOS] | (r_reg.quiet[p] == 8'(QUIET_CYC));
      r_next.oof[p] = cur[`SLM_IN_OOF] | r_next.los[p];
      // Counter restarts on every change of the frame state
      if (r_next.oof[p] != r_reg.oof[p]) begin
        r_next.lof_cnt[p] = '0;
      end else if (r_reg.lof_cnt[p] != CW'(CNT_MAX + 1)) begin
        r_next.lof_cnt[p] = r_reg.lof_cnt[p] + CW'(1);
      end
      if (r_reg.oof[p] && r_reg.lof_cnt[p] >= CW'(LOF_SET_CYC)) begin
        r_next.lof[p] = 1'b1;
      end else if (!r_reg.oof[p] && r_reg.lof_cnt[p] >= CW'(LOF_CLR_CYC)) begin
        r_next.lof[p] = 1'b0;
      end
      // Parity toggles: a new error beats a clear in the same cycle
      r_next.bip[p] = (r_reg.bip[p] & ~{3{rd_clr[p]}}) |
                      (cur[`SLM_IN_BIP_LO +: 3] ^ r_reg.prev[p][`SLM_IN_BIP_LO +: 3]);
      r_next.c2chg[p] = r_reg.c2chg[p] & ~rd_clr[p];
      if (lclk_rise && c2_now == r_reg.prev[p][`SLM_IN_C2_LO +: 8]) begin
        r_next.c2[p] = c2_now;
        r_next.c2_seen[p] = 1'b1;
        if (r_reg.c2_seen[p] && c2_now != r_reg.c2[p]) begin
          r_next.c2chg[p] = 1'b1;
        end
      end
      if (!concat_cfg && cur[`SLM_IN_RCONC]) begin
        r_next.ptr[p] = SLM_PTR_CONC;
      end else if (cur[`SLM_IN_PLOCK] && !r_next.oof[p]) begin
        r_next.ptr[p] = SLM_PTR_VALID;
      end else begin
        r_next.ptr[p] = SLM_PTR_LOP;
      end
      r_next.vc[p] = (concat_cfg || cur[`SLM_IN_RCONC]) ? 8'h00 : cur[`SLM_IN_VC_LO +: 8];
      r_next.tx_loop[p] = ~cfg_words[p][`SLM_CFG_MASTER];
      r_next.prev[p] = cur;
    end
    // One wait state: the answer is prepared in the first access cycle
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    if (acc && !r_reg.pready) begin
      r_next.pready = 1'b1;
      r_next.pslverr = ~d[IW+1];
      if (!d[IW+1] || pwrite) begin
        r_next.prdata = 32'h0000_0000;
      end else if (d[IW]) begin
        r_next.prdata = stat_word(r_reg, int'(d[IW-1:0]));
      end else begin
        r_next.prdata = cfg_rdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      cfg_oc12[p] = cfg_words[p][`SLM_CFG_OC12];
      cfg_master[p] = cfg_words[p][`SLM_CFG_MASTER];
      concatenated_mapping[p] = cfg_words[p][`SLM_CFG_CONCAT];
      cfg_pos[p] = cfg_words[p][`SLM_CFG_POS];
      cfg_crc[p] = cfg_words[p][`SLM_CFG_CRC_LO +: 2];
      cfg_pass_idle[p] = cfg_words[p][`SLM_CFG_IDLE];
      optics_pwr[p] = cfg_words[p][`SLM_CFG_PWR];
      rec_len[p] = cfg_words[p][`SLM_CFG_LEN_LO +: 16];
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign tx_clk_loop = r_reg.tx_loop;
  assign los_out = r_reg.los;
  assign lof_out = r_reg.lof;
  assign oof_out = r_reg.oof;
  assign pointer_state = r_reg.ptr;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [CW-1:0] oof_run;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oof_run <= '0;
    end else if (!oof_out[0]) begin
      oof_run <= '0;
    end else if (oof_run != CW'(CNT_MAX + 1)) begin
      oof_run <= oof_run + CW'(1);
    end
  end

  sequence s_bip_event;
    sync_q[0][`SLM_IN_BIP_LO] != r_reg.prev[0][`SLM_IN_BIP_LO];
  endsequence

  sequence s_apb_wait;
    acc && !pready ##1 pready;
  endsequence

  a_lof_needs_hold: assert property ($rose(lof_out[0]) |-> oof_run > CW'(LOF_SET_CYC))
    else $error("loss of frame raised before out of frame held long enough");
  a_lof_sets_late: assert property (oof_run == CW'(LOF_SET_CYC + 2) |-> lof_out[0])
    else $error("loss of frame missing after long out of frame");
  a_oof_follows: assert property (sync_q[0][`SLM_IN_OOF] |=> oof_out[0])
    else $error("out of frame not reported");
  a_los_follows: assert property (sync_q[0][`SLM_IN_LOS] |=> los_out[0] ##0 oof_out[0])
    else $error("loss of signal not reported");
  a_bip_latched: assert property (s_bip_event ##1 !rd_clr[0] |=> r_reg.bip[0][0])
    else $error("section parity error lost");
  a_c2_taken: assert property (
      sync_q[0][`SLM_IN_LCLK] && !r_reg.prev[0][`SLM_IN_LCLK] &&
      sync_q[0][`SLM_IN_C2_LO +: 8] == r_reg.prev[0][`SLM_IN_C2_LO +: 8]
      |=> r_reg.c2[0] == $past(sync_q[0][`SLM_IN_C2_LO +: 8]))
    else $error("path label not captured");
  a_ptr_valid_framed: assert property (pointer_state[0] == SLM_PTR_VALID |-> !oof_out[0])
    else $error("pointer valid while out of frame");
  a_ptr_conc: assert property (!concatenated_mapping[2] && sync_q[2][`SLM_IN_RCONC]
      |=> pointer_state[2] == SLM_PTR_CONC)
    else $error("concatenation mismatch not reported");
  a_vc_zero: assert property (concatenated_mapping[0] && $past(concatenated_mapping[0])
      |-> r_reg.vc[0] == 8'h00)
    else $error("container number not zero when concatenated");
  a_read_clears: assert property (rd_clr[0] &&
      sync_q[0][`SLM_IN_BIP_LO] == r_reg.prev[0][`SLM_IN_BIP_LO]
      |=> r_reg.bip[0][0] == 1'b0)
    else $error("parity flag not cleared by read");
  a_apb_one_wait: assert property (acc && !pready |-> s_apb_wait ##1 !pready)
    else $error("register answer not after exactly one wait");
  a_loop_slave: assert property (!cfg_master[0] && $past(!cfg_master[0]) |-> tx_clk_loop[0])
    else $error("slave port does not loop receive clock");
endmodule : slm_top
`default_nettype wire

// ===== slm_defs.svh
// Constants of the SONET line status monitor: offsets, fields, resets, timing
// ============================================================================
// Operation
// - LOF after OOF held over 2 ms
// - OOF when overhead framer not locked
// - LOS on no signal or weak light
// - Separate B1, B2, B3 parity error flags
// - Present received C2 label as byte
// - Pointer state valid or loss of pointer
// - Conc pointer state on channelised/concatenated mismatch; the code sets it only for a concatenated signal on a port set channelised
// - VC number reads zero when concatenated
// - Status bit one while condition present; the parity and C2 change flags stay set until the status word is read
// - Independent framing settings per port
// - Rate, clock role and mapping per port
// - Per-port optics module power control
// - Report valid optical signal per transceiver
// - Configurable capture record length
// - Master internal tx clock, slave loops
// - Per-port ATM or PoS mode select
// - PoS CRC16, CRC32 or no check
// - ATM idle cells passed or discarded
`ifndef SLM_DEFS_SVH
`define SLM_DEFS_SVH

// ============================================================================
// Timing
`define SLM_PCLK_MHZ 125
`define SLM_PCLK_NS 8
`define SLM_LOF_SET_MS 2
`define SLM_LOF_CLR_MS 2
`define SLM_CLKLOSS_NS 480
`define SLM_NUM_PORTS 4

// ============================================================================
// Register map
`define SLM_CFG_BASE 8'h00
`define SLM_STAT_BASE 8'h10
`define SLM_CFG_RST 32'h003000a7

// Port configuration word fields
`define SLM_CFG_OC12 0
`define SLM_CFG_MASTER 1
`define SLM_CFG_CONCAT 2
`define SLM_CFG_POS 3
`define SLM_CFG_CRC_LO 4
`define SLM_CFG_IDLE 6
`define SLM_CFG_PWR 7
`define SLM_CFG_LEN_LO 16

// Port status word fields
`define SLM_ST_LOS 0
`define SLM_ST_LOF 1
`define SLM_ST_OOF 2
`define SLM_ST_BIP_LO 3
`define SLM_ST_C2CHG 6
`define SLM_ST_PTR_LO 7
`define SLM_ST_SIG 9
`define SLM_ST_MOD 10
`define SLM_ST_LASER 11
`define SLM_ST_C2_LO 16
`define SLM_ST_VC_LO 24

// Layout of one port's synchronised input vector
`define SLM_IN_LCLK 0
`define SLM_IN_LOS 1
`define SLM_IN_OOF 2
`define SLM_IN_SIG 3
`define SLM_IN_MOD 4
`define SLM_IN_LASER 5
`define SLM_IN_BIP_LO 6
`define SLM_IN_PLOCK 9
`define SLM_IN_RCONC 10
`define SLM_IN_C2_LO 11
`define SLM_IN_VC_LO 19
`define SLM_IN_W 27

`endif

// ===== slm_pkg.sv
// Types shared by the SONET line status monitor
package slm_pkg;
  typedef enum logic [1:0] {SLM_PTR_LOP, SLM_PTR_VALID, SLM_PTR_CONC} slm_ptr_t;
  typedef enum logic [1:0] {SLM_CRC_NONE, SLM_CRC_16, SLM_CRC_32} slm_crc_t;
endpackage : slm_pkg

// ===== slm_sync.sv
// Two-flop level synchroniser for a bundle of independent bits
`timescale 1ns/1ps
`default_nettype none
module slm_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } slm_sync_st_t;

  slm_sync_st_t st_reg;
  slm_sync_st_t st_next;

  // First stage feeds only the second stage
  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.s2;
endmodule : slm_sync
`default_nettype wire

// ===== slm_cfg_mem.sv
// Per-port configuration word store with registered read port
`timescale 1ns/1ps
`default_nettype none
`include "slm_defs.svh"
module slm_cfg_mem import slm_pkg::*; #(
  parameter int NP = `SLM_NUM_PORTS,
  parameter int IW = $clog2(NP)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [IW-1:0] waddr,
  input wire logic [31:0] wdata,
  // Read port
  input wire logic [IW-1:0] raddr,
  output logic [31:0] rdata,
  // All words, for the datapath
  output logic [NP-1:0][31:0] words
);
  typedef struct packed {
    logic [NP-1:0][31:0] mem;
    logic [31:0] rdata;
  } slm_mem_st_t;

  slm_mem_st_t st_reg;
  slm_mem_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (we) begin
      st_next.mem[waddr] = wdata;
    end
    st_next.rdata = st_reg.mem[raddr];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.mem <= {NP{`SLM_CFG_RST}};
      st_reg.rdata <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign words = st_reg.mem;
endmodule : slm_cfg_mem
`default_nettype wire

// ===== slm_line_model.sv
// Far-end SONET line equipment model driving the monitor's line-side pins
`timescale 1ns/1ps
`default_nettype none
module slm_line_model #(
  parameter int NP = 4
) (
  // Commands from the bench
  input wire logic [NP-1:0] run,
  input wire logic [NP-1:0] los_c,
  input wire logic [NP-1:0] oof_c,
  input wire logic [NP-1:0] sig_c,
  input wire logic [NP-1:0] lock_c,
  input wire logic [NP-1:0] conc_c,
  input wire logic [NP-1:0][2:0] bip_c,
  input wire logic [NP-1:0][7:0] c2_c,
  input wire logic [NP-1:0][7:0] vc_c,
  // Line side of the monitor
  output logic [NP-1:0] line_clk,
  output logic [NP-1:0] los_in,
  output logic [NP-1:0] oof_in,
  output logic [NP-1:0] sig_detect,
  output logic [NP-1:0] mod_present,
  output logic [NP-1:0] laser_on,
  output logic [NP-1:0] b1_err_tgl,
  output logic [NP-1:0] b2_err_tgl,
  output logic [NP-1:0] b3_err_tgl,
  output logic [NP-1:0] ptr_lock_in,
  output logic [NP-1:0] rx_concat_in,
  output logic [NP-1:0][7:0] c2_in,
  output logic [NP-1:0][7:0] vc_in
);
  logic lclk = 1'b0;
  // Recovered clock, phase unrelated to pclk; it stops when the fibre is pulled
  // First edge comes early so every pin holds a defined level before reset ends
  initial begin
    #3 lclk = 1'b1;
    forever #80 lclk = ~lclk;
  end
  assign line_clk = {NP{lclk}} & run;
  assign mod_present = {NP{1'b1}};
  assign laser_on = {NP{1'b0}};
  // Far end matches rate, role and mapping; only commanded faults break lock
  always @(posedge lclk) begin
    los_in <= los_c;
    oof_in <= oof_c;
    sig_detect <= sig_c;
    ptr_lock_in <= lock_c;
    rx_concat_in <= conc_c;
    for (int p = 0; p < NP; p++) begin
      {b3_err_tgl[p], b2_err_tgl[p], b1_err_tgl[p]} <= bip_c[p];
    end
    c2_in <= c2_c;
    vc_in <= vc_c;
  end
endmodule : slm_line_model
`default_nettype wire

// ===== sonet_line_status_monitor_tb_top.sv
// Self-checking bench of the line status monitor against a reference model
`timescale 1ns/1ps
`default_nettype none
module sonet_line_status_monitor_tb_top;
  localparam int LOFC = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv, w;
  logic [3:0] pstrb;
  logic er;
  logic [3:0] line_clk, los_in, oof_in, sig_detect, mod_present, laser_on, ptr_lock_in;
  logic [3:0] b1_err_tgl, b2_err_tgl, b3_err_tgl, rx_concat_in;
  logic [3:0][7:0] c2_in, vc_in, c2_c, vc_c;
  logic [3:0] cfg_oc12, cfg_master, concatenated_mapping, cfg_pos, cfg_pass_idle, optics_pwr;
  logic [3:0] tx_clk_loop, los_out, lof_out, oof_out;
  logic [3:0][1:0] cfg_crc, pointer_state;
  logic [3:0][15:0] rec_len;
  logic [3:0] run, los_c, oof_c, sig_c, lock_c, conc_c;
  logic [3:0][2:0] bip_c;
  logic [31:0] cfg_m [4];
  logic [2:0] bip_m [4];
  logic c2chg_m [4];
  logic lof_m [4];
  int fails, checked, seed;

  slm_top #(.LOF_SET_CYC(LOFC), .LOF_CLR_CYC(LOFC)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_clk(line_clk),
    .los_in(los_in), .oof_in(oof_in), .sig_detect(sig_detect), .mod_present(mod_present),
    .laser_on(laser_on), .b1_err_tgl(b1_err_tgl), .b2_err_tgl(b2_err_tgl),
    .b3_err_tgl(b3_err_tgl), .ptr_lock_in(ptr_lock_in), .rx_concat_in(rx_concat_in),
    .c2_in(c2_in), .vc_in(vc_in), .cfg_oc12(cfg_oc12), .cfg_master(cfg_master),
    .concatenated_mapping(concatenated_mapping), .cfg_pos(cfg_pos), .cfg_crc(cfg_crc),
    .cfg_pass_idle(cfg_pass_idle), .optics_pwr(optics_pwr), .rec_len(rec_len),
    .tx_clk_loop(tx_clk_loop), .los_out(los_out), .lof_out(lof_out), .oof_out(oof_out),
    .pointer_state(pointer_state));

  slm_line_model #(.NP(4)) u_line (.run(run), .los_c(los_c), .oof_c(oof_c), .sig_c(sig_c),
    .lock_c(lock_c), .conc_c(conc_c), .bip_c(bip_c), .c2_c(c2_c), .vc_c(vc_c),
    .line_clk(line_clk), .los_in(los_in), .oof_in(oof_in), .sig_detect(sig_detect),
    .mod_present(mod_present), .laser_on(laser_on), .b1_err_tgl(b1_err_tgl),
    .b2_err_tgl(b2_err_tgl), .b3_err_tgl(b3_err_tgl), .ptr_lock_in(ptr_lock_in),
    .rx_concat_in(rx_concat_in), .c2_in(c2_in), .vc_in(vc_in));

  // =====================================================================
  // Checking helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // Expected status word from what the far end is sending
  function automatic logic [31:0] exp_st(int p);
    logic los, oof;
    logic [1:0] ptr;
    logic [7:0] vc;
    los = los_c[p] | ~run[p];
    oof = oof_c[p] | los;
    if (!cfg_m[p][2] && conc_c[p]) ptr = 2'h2;
    else if (lock_c[p] && !oof) ptr = 2'h1;
    else ptr = 2'h0;
    vc = (cfg_m[p][2] || conc_c[p]) ? 8'h00 : vc_c[p];
    return {vc, c2_c[p], 4'h0, 1'b0, 1'b1, sig_c[p], ptr, c2chg_m[p], bip_m[p], oof,
            lof_m[p], los};
  endfunction : exp_st

  // =====================================================================
  // APB master: hold the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr_cfg(input int p, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, 8'(4 * p), d, s, rdv, er);
    for (int b = 0; b < 4; b++) if (s[b]) cfg_m[p][8*b+:8] = d[8*b+:8];
    repeat (2) @(posedge pclk);
    chk("cfg_out", {rec_len[p], 8'h00, optics_pwr[p], cfg_pass_idle[p], cfg_crc[p], cfg_pos[p],
        concatenated_mapping[p], cfg_master[p], cfg_oc12[p]}, cfg_m[p]);
    chk("tx_loop", {31'h0, tx_clk_loop[p]}, {31'h0, ~cfg_m[p][1]});
    apb(1'b0, 8'(4 * p), 32'h0, 4'h0, rdv, er);
    chk("cfg_rd", rdv, cfg_m[p]);
  endtask : wr_cfg

  task automatic rd_st(input int p);
    logic [31:0] ex;
    apb(1'b0, 8'(8'h10 + 4 * p), 32'h0, 4'h0, rdv, er);
    ex = exp_st(p);
    chk("status", rdv, ex);
    chk("los_oof", {30'h0, los_out[p], oof_out[p]}, {30'h0, ex[0], ex[2]});
    chk("ptr_out", {30'h0, pointer_state[p]}, {30'h0, ex[8:7]});
    bip_m[p] = 3'h0;
    c2chg_m[p] = 1'b0;
  endtask : rd_st

  task automatic wait_oof(input int p, input logic v);
    int n;
    n = 0;
    while (oof_out[p] !== v && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 100) fails++;
  endtask : wait_oof

  // =====================================================================
  // Clock, watchdog and stimulus
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    #400000;
    fails++;
    end_sim();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    presetn = 1'b0;
    fails = 0;
    checked = 0;
    seed = 32'h068f;
    run = 4'hf;
    {los_c, oof_c, conc_c} = '0;
    {sig_c, lock_c} = 8'hff;
    bip_c = '0;
    c2_c = {8'h13, 8'hcf, 8'h16, 8'h16};
    vc_c = {4{8'h05}};
    for (int p = 0; p < 4; p++) begin
      cfg_m[p] = 32'h003000a7;
      {bip_m[p], c2chg_m[p], lof_m[p]} = '0;
    end
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (100) @(posedge pclk);
    for (int p = 0; p < 4; p++) begin
      wr_cfg(p, 32'h0, 4'h0);
      rd_st(p);
    end
    // Independent random settings, then two partial-strobe writes
    for (int p = 0; p < 4; p++) begin
      w = $random(seed);
      w[15:8] = 8'h00;
      w[5:4] = 2'(w[15:0] % 3);
      wr_cfg(p, w, 4'hf);
    end
    wr_cfg(3, 32'h0800_5a5a, 4'b1100);
    wr_cfg(0, 32'h0000_0000, 4'b0001);
    // Refused and ignored accesses
    apb(1'b0, 8'h40, 32'h0, 4'h0, rdv, er);
    chk("unmapped", {er, rdv}, {1'b1, 32'h0});
    apb(1'b1, 8'h02, 32'hffffffff, 4'hf, rdv, er);
    chk("unaligned", {31'h0, er}, 32'h1);
    apb(1'b1, 8'h10, 32'hffffffff, 4'hf, rdv, er);
    chk("st_wr_err", {31'h0, er}, 32'h0);
    rd_st(0);
    // Pointer states and container number on a channelised port
    wr_cfg(2, 32'h00300003, 4'hf);
    conc_c[2] = 1'b1;
    repeat (100) @(posedge pclk);
    rd_st(2);
    conc_c[2] = 1'b0;
    vc_c[2] = 8'($random(seed));
    repeat (100) @(posedge pclk);
    rd_st(2);
    lock_c[2] = 1'b0;
    sig_c[2] = 1'b0;
    repeat (100) @(posedge pclk);
    rd_st(2);
    // Parity flags stick until read
    for (int k = 0; k < 3; k++) begin
      bip_c[0][k] = ~bip_c[0][k];
      bip_m[0][k] = 1'b1;
      repeat (60) @(posedge pclk);
      rd_st(0);
      rd_st(0);
    end
    // Changing path label
    c2_c[1] = 8'($random(seed)) | 8'h01;
    c2chg_m[1] = 1'b1;
    repeat (100) @(posedge pclk);
    rd_st(1);
    rd_st(1);
    // Loss of signal: stopped clock, then weak light
    run[0] = 1'b0;
    lof_m[0] = 1'b1;
    repeat (100) @(posedge pclk);
    rd_st(0);
    run[0] = 1'b1;
    los_c[0] = 1'b1;
    repeat (100) @(posedge pclk);
    rd_st(0);
    los_c[0] = 1'b0;
    lof_m[0] = 1'b0;
    repeat (100) @(posedge pclk);
    rd_st(0);
    // Frame loss timing set and clear, on the last cycle before each timer edge and two cycles later
    oof_c[0] = 1'b1;
    wait_oof(0, 1'b1);
    repeat (LOFC) @(posedge pclk);
    chk("lof_early", {31'h0, lof_out[0]}, 32'h0);
    repeat (2) @(posedge pclk);
    chk("lof_set", {31'h0, lof_out[0]}, 32'h1);
    lof_m[0] = 1'b1;
    rd_st(0);
    oof_c[0] = 1'b0;
    wait_oof(0, 1'b0);
    repeat (LOFC) @(posedge pclk);
    chk("lof_hold", {31'h0, lof_out[0]}, 32'h1);
    repeat (2) @(posedge pclk);
    chk("lof_clr", {31'h0, lof_out[0]}, 32'h0);
    lof_m[0] = 1'b0;
    rd_st(0);
    end_sim();
  end
endmodule : sonet_line_status_monitor_tb_top
`default_nettype wire
